// File: design/ufr_params.svh
/*
  Timing, geometry and code constants of the 2B1Q U-interface framer.
  Assumes a 100 MHz system clock; included by bare name.
*/
`ifndef UFR_PARAMS_SVH
`define UFR_PARAMS_SVH

// ==========================================
// Timing
`define UFR_CLK_MHZ 100
`define UFR_QUAT_NS 12500
`define UFR_QUAT_CYC ((`UFR_QUAT_NS * `UFR_CLK_MHZ) / 1000)

// ==========================================
// Frame geometry, quat indices from zero
`define UFR_FRAME_QUATS 120
`define UFR_SYNC_QUATS 9
`define UFR_DATA_LAST 116
`define UFR_M12_POS 117
`define UFR_M34_POS 118
`define UFR_M56_POS 119
`define UFR_SF_FRAMES 8

// ==========================================
// Codes
`define UFR_SYNC_WORD 18'h2808a
`define UFR_SIGN_MASK 18'h2aaaa
`define UFR_SCR_ORDER 23
`define UFR_SCR_TAP_TX 5
`define UFR_SCR_TAP_RX 18
`define UFR_CRC_W 12
`define UFR_CRC_POLY 12'h80f
`define UFR_LAG_QUATS 60
`define UFR_LAG_TOL 2

`endif

// File: design/ufr_pkg.sv
/*
  Types shared by the framer, scrambler and CRC modules.
  Assumes nothing of its surroundings.
*/
package ufr_pkg;
  typedef struct packed {
    logic sign;
    logic mag;
  } ufr_quat_t;

  typedef struct packed {
    logic valid;
    logic sync;
    ufr_quat_t q;
    logic signed [2:0] level;
  } ufr_tx_sym_t;

  typedef struct packed {
    logic [2:0] addr;
    logic dm;
    logic [7:0] info;
  } ufr_eoc_t;

  typedef struct packed {
    ufr_eoc_t eoc;
    logic act;
    logic dea;
    logic uoa;
    logic aib;
  } ufr_ovh_t;

  typedef struct packed {
    logic valid;
    logic [2:0] frame;
    logic [5:0] m;
  } ufr_rx_m_t;

  typedef enum logic [0:0] {UFR_HUNT, UFR_LOCK} ufr_rx_state_t;
endpackage

// File: design/ufr_scrambler.sv
/*
  Self-synchronizing scrambler or descrambler, one quat per step.
  Assumes the caller steps it only on non-sync quats.
*/
`timescale 1ns/1ps
`default_nettype none
module ufr_scrambler #(
  parameter int ORDER = 23,
  parameter int TAP = 5,
  parameter bit DESCR = 1'b0
) (
  input wire logic clk, // System clock
  input wire logic rst, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic step, // Advance one quat
  input wire ufr_pkg::ufr_quat_t din, // Quat in
  output ufr_pkg::ufr_quat_t dout // Quat out, combinational
);
  logic [ORDER-1:0] sr_q;
  logic [ORDER-1:0] sr_d;

  always_comb begin
    logic [ORDER-1:0] s;
    s = sr_q;
    // Sign bit first, then magnitude
    dout.sign = din.sign ^ s[TAP-1] ^ s[ORDER-1];
    s = {s[ORDER-2:0], DESCR ? din.sign : dout.sign};
    dout.mag = din.mag ^ s[TAP-1] ^ s[ORDER-1];
    s = {s[ORDER-2:0], DESCR ? din.mag : dout.mag};
    sr_d = step ? s : sr_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sr_q <= '0;
    end else if (ce) begin
      sr_q <= sr_d;
    end
  end
endmodule // ufr_scrambler
`default_nettype wire

// File: design/ufr_crc.sv
/*
  Serial CRC over up to two bits per step, sign bit first.
  Assumes clear and enables are not raised in the same step.
*/
`timescale 1ns/1ps
`default_nettype none
module ufr_crc #(
  parameter int W = 12,
  parameter logic [W-1:0] POLY = 12'h80f
) (
  input wire logic clk, // System clock
  input wire logic rst, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic clr, // Restart the check
  input wire logic en_s, // Take sign bit
  input wire logic en_m, // Take magnitude bit
  input wire ufr_pkg::ufr_quat_t d, // Bits in
  output logic [W-1:0] crc // Running remainder
);
  logic [W-1:0] crc_q;
  logic [W-1:0] crc_d;

  function automatic logic [W-1:0] crc_bit(input logic [W-1:0] c, input logic b);
    logic fb;
    fb = c[W-1] ^ b;
    crc_bit = {c[W-2:0], 1'b0} ^ (fb ? POLY : '0);
  endfunction

  always_comb begin
    crc_d = crc_q;
    if (en_s) begin
      crc_d = crc_bit(crc_d, d.sign);
    end
    if (en_m) begin
      crc_d = crc_bit(crc_d, d.mag);
    end
    if (clr) begin
      crc_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crc_q <= '0;
    end else if (ce) begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
endmodule // ufr_crc
`default_nettype wire

// File: design/ufr_framer.sv
/*
  2B1Q U-interface framer: quat coding, frame and superframe build,
  scrambling, overhead bits and CRC on transmit; sync hunt, descrambling,
  overhead capture and CRC check on receive.
  Assumes the received quats come from same-clock detector logic.
*/
// Operation
// [R1] Two bits form one four-level symbol
// [R2] Sign-magnitude map 10 11 01 00 to +3 +1 -1 -3
// [R3] 120 quats per frame, 80 kquat/s
// [R4] Nine-quat syncword starts every frame
// [R5] Eight frames make one superframe
// [R6] Frame one sends inverted syncword
// [R7] Scramble everything except the syncword
// [R8] Descramble received bits except the syncword
// [R9] Sync, 2B+D, then M1 to M6 bits
// [R10] M1 to M3 carry the EOC fields
// [R11] M4 carries act, dea, uoa, aib, else one
// [R12] M5 one early; M6 one, then febe
// [R13] Twelve CRC bits in frames three to eight
// [R14] CRC covers 2B+D and M4 bits
// [R15] Febe zero after an errored superframe
// [R16] Return superframe lags by 60 quats
// [R17] M4 layout is network-to-NT direction
`include "ufr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ufr_framer #(
  parameter int QUAT_CYC = `UFR_QUAT_CYC,
  parameter logic [17:0] SYNC_WORD = `UFR_SYNC_WORD,
  parameter int TAP_TX = `UFR_SCR_TAP_TX,
  parameter int TAP_RX = `UFR_SCR_TAP_RX
) (
  input wire logic clk, // System clock
  input wire logic rst, // Sync reset
  input wire logic ce, // Clock enable
  input wire ufr_pkg::ufr_quat_t tx_user_bits, // Next 2B+D bit pair
  input wire ufr_pkg::ufr_ovh_t tx_ovh, // Overhead bits to send
  output logic tx_user_take, // Bit pair consumed
  output ufr_pkg::ufr_tx_sym_t tx_sym, // Line symbol
  input wire logic rx_quat_valid, // Received quat strobe
  input wire ufr_pkg::ufr_quat_t rx_quat, // Received quat
  output logic rx_user_valid, // Received 2B+D pair strobe
  output ufr_pkg::ufr_quat_t rx_user_bits, // Descrambled pair
  output ufr_pkg::ufr_rx_m_t rx_m, // M1..M6 of a received frame
  output logic rx_locked, // Superframe lock held
  output logic rx_crc_err, // Last checked superframe errored
  output logic rx_lag_ok // Return superframe offset in window
);
  localparam int CW = (QUAT_CYC > 1) ? $clog2(QUAT_CYC) : 1;
  localparam logic [6:0] LAST_POS = 7'(`UFR_FRAME_QUATS - 1);

  // ==========================================
  // Functions
  function automatic ufr_pkg::ufr_quat_t sync_quat(input logic [6:0] p, input logic inv);
    logic [17:0] w;
    w = inv ? (SYNC_WORD ^ `UFR_SIGN_MASK) : SYNC_WORD;
    w = w << {p[3:0], 1'b0};
    sync_quat = w[17:16];
  endfunction

  function automatic logic signed [2:0] quat_level(input ufr_pkg::ufr_quat_t q);
    case ({q.sign, q.mag})
      2'h2: quat_level = 3'sh3;
      2'h3: quat_level = 3'sh1;
      2'h1: quat_level = 3'sh7;
      default: quat_level = 3'sh5;
    endcase
  endfunction

  function automatic logic [5:0] m_bits(input logic [2:0] f, input ufr_pkg::ufr_ovh_t o,
                                        input logic [11:0] c, input logic fb);
    logic [2:0] eoc;
    logic m4;
    logic [1:0] m56;
    logic [11:0] cs;
    cs = c << {f - 3'h2, 1'b0};
    case (f[1:0])
      2'h0: eoc = o.eoc.addr; // R10
      2'h1: eoc = {o.eoc.dm, o.eoc.info[7:6]}; // R10
      2'h2: eoc = o.eoc.info[5:3];
      default: eoc = o.eoc.info[2:0];
    endcase
    case (f)
      3'h0: m4 = o.act; // R11
      3'h1: m4 = o.dea; // R11
      3'h6: m4 = o.uoa; // R11
      3'h7: m4 = o.aib; // R17
      default: m4 = 1'b1;
    endcase
    if (f == 3'h0) begin
      m56 = 2'h3; // R12
    end else if (f == 3'h1) begin
      m56 = {1'b1, fb}; // R12
    end else begin
      m56 = cs[11:10]; // R13
    end
    m_bits = {eoc, m4, m56};
  endfunction

  // ==========================================
  // Transmit
  logic [CW-1:0] cnt_q, cnt_d;
  logic [6:0] tx_pos_q, tx_pos_d, emit_pos_q, emit_pos_d;
  logic [2:0] tx_frame_q, tx_frame_d, emit_frame_q, emit_frame_d;
  ufr_pkg::ufr_ovh_t ovh_q, ovh_d;
  logic [11:0] crc_prev_q, crc_prev_d, tx_crc;
  ufr_pkg::ufr_tx_sym_t sym_q, sym_d;
  ufr_pkg::ufr_quat_t plain_q, plain_d, plain, line, scr_out;
  logic take_q, take_d, febe_q;
  logic tick, is_sync, is_data, sf_end;
  logic [5:0] mtx;

  always_comb begin
    tick = (cnt_q == CW'(QUAT_CYC - 1)); // R3
    cnt_d = tick ? '0 : cnt_q + 1'b1;
    is_sync = (tx_pos_q < 7'(`UFR_SYNC_QUATS));
    is_data = !is_sync && (tx_pos_q <= 7'(`UFR_DATA_LAST));
    sf_end = tick && (tx_pos_q == LAST_POS) && (tx_frame_q == 3'h7);
    mtx = m_bits(tx_frame_q, ovh_q, crc_prev_q, febe_q);
    if (is_sync) begin
      plain = sync_quat(tx_pos_q, tx_frame_q == 3'h0); // R4 R6
    end else if (is_data) begin
      plain = tx_user_bits; // R9
    end else if (tx_pos_q == 7'(`UFR_M12_POS)) begin
      plain = mtx[5:4];
    end else if (tx_pos_q == 7'(`UFR_M34_POS)) begin
      plain = mtx[3:2];
    end else begin
      plain = mtx[1:0];
    end
    line = is_sync ? plain : scr_out; // R7
    tx_pos_d = tx_pos_q;
    tx_frame_d = tx_frame_q;
    emit_pos_d = emit_pos_q;
    emit_frame_d = emit_frame_q;
    plain_d = plain_q;
    ovh_d = ovh_q;
    crc_prev_d = sf_end ? tx_crc : crc_prev_q;
    sym_d = '0;
    take_d = tick && is_data;
    if (tick) begin
      sym_d = {1'b1, is_sync, line, quat_level(line)}; // R1 R2
      emit_pos_d = tx_pos_q;
      emit_frame_d = tx_frame_q;
      plain_d = plain;
      if (tx_pos_q == 7'h0 && tx_frame_q[1:0] == 2'h0) begin
        ovh_d = tx_ovh;
      end
      if (tx_pos_q == LAST_POS) begin
        tx_pos_d = 7'h0; // R3
        tx_frame_d = tx_frame_q + 3'h1; // R5
      end else begin
        tx_pos_d = tx_pos_q + 7'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      tx_pos_q <= 7'h0;
      tx_frame_q <= 3'h0;
      emit_pos_q <= 7'h0;
      emit_frame_q <= 3'h0;
      ovh_q <= '1;
      crc_prev_q <= '0;
      sym_q <= '0;
      plain_q <= '0;
      take_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      tx_pos_q <= tx_pos_d;
      tx_frame_q <= tx_frame_d;
      emit_pos_q <= emit_pos_d;
      emit_frame_q <= emit_frame_d;
      ovh_q <= ovh_d;
      crc_prev_q <= crc_prev_d;
      sym_q <= sym_d;
      plain_q <= plain_d;
      take_q <= take_d;
    end
  end

  ufr_scrambler #(.ORDER(`UFR_SCR_ORDER), .TAP(TAP_TX), .DESCR(1'b0)) u_scr (
    .clk(clk), .rst(rst), .ce(ce), .step(tick && !is_sync), // R7
    .din(plain), .dout(scr_out)
  );

  ufr_crc #(.W(`UFR_CRC_W), .POLY(`UFR_CRC_POLY)) u_tx_crc (
    .clk(clk), .rst(rst), .ce(ce), .clr(sf_end),
    .en_s(tick && is_data), // R14
    .en_m(tick && (is_data || tx_pos_q == 7'(`UFR_M34_POS))), // R14
    .d(plain), .crc(tx_crc)
  );

  // ==========================================
  // Receive
  ufr_pkg::ufr_rx_state_t st_q, st_d;
  logic [17:0] hist_q, hist_d;
  logic [6:0] rx_pos_q, rx_pos_d;
  logic [2:0] rx_frame_q, rx_frame_d;
  logic [3:0] mbuf_q, mbuf_d;
  logic [9:0] rcv_q, rcv_d;
  logic [11:0] rx_crc, rx_prev_q, rx_prev_d, full;
  logic chk_q, chk_d, err_q, err_d, febe_d, lag_q, lag_d, uv_d;
  ufr_pkg::ufr_quat_t desc, ub_d;
  ufr_pkg::ufr_rx_m_t rxm_d;
  logic step, sw_hit, isw_hit, r_data, r_end;
  logic [9:0] tx_idx;

  always_comb begin
    step = rx_quat_valid;
    hist_d = step ? {hist_q[15:0], rx_quat} : hist_q;
    sw_hit = (hist_d == SYNC_WORD);
    isw_hit = (hist_d == (SYNC_WORD ^ `UFR_SIGN_MASK)); // R6
    r_data = step && st_q == ufr_pkg::UFR_LOCK && rx_pos_q >= 7'(`UFR_SYNC_QUATS)
             && rx_pos_q <= 7'(`UFR_DATA_LAST);
    r_end = step && st_q == ufr_pkg::UFR_LOCK && rx_pos_q == LAST_POS
            && rx_frame_q == 3'h7;
    full = {rcv_q, desc};
    tx_idx = 10'(tx_frame_q) * 10'h78 + 10'(tx_pos_q);
    st_d = st_q;
    rx_pos_d = rx_pos_q;
    rx_frame_d = rx_frame_q;
    mbuf_d = mbuf_q;
    rcv_d = rcv_q;
    rx_prev_d = rx_prev_q;
    chk_d = chk_q;
    err_d = err_q;
    febe_d = febe_q;
    lag_d = lag_q;
    uv_d = r_data;
    ub_d = r_data ? desc : '0;
    rxm_d = '0;
    if (step && isw_hit) begin
      // Offset at last return sync quat; tx index already one past launch
      lag_d = (tx_idx >= 10'(`UFR_LAG_QUATS + `UFR_SYNC_QUATS - `UFR_LAG_TOL))
           && (tx_idx <= 10'(`UFR_LAG_QUATS + `UFR_SYNC_QUATS + `UFR_LAG_TOL)); // R16
    end
    case (st_q)
      ufr_pkg::UFR_HUNT: begin
        if (step && isw_hit) begin
          st_d = ufr_pkg::UFR_LOCK;
          rx_pos_d = 7'(`UFR_SYNC_QUATS);
          rx_frame_d = 3'h0;
        end
      end
      default: begin
        if (step) begin
          rx_pos_d = (rx_pos_q == LAST_POS) ? 7'h0 : rx_pos_q + 7'h1;
          if (rx_pos_q == LAST_POS) begin
            rx_frame_d = rx_frame_q + 3'h1;
          end
          if (rx_pos_q == 7'(`UFR_SYNC_QUATS - 1)) begin
            if (!(sw_hit || isw_hit)) begin
              st_d = ufr_pkg::UFR_HUNT;
            end else if (isw_hit) begin
              rx_frame_d = 3'h0;
            end
          end
          if (rx_pos_q == 7'(`UFR_M12_POS)) begin
            mbuf_d[3:2] = desc;
          end
          if (rx_pos_q == 7'(`UFR_M34_POS)) begin
            mbuf_d[1:0] = desc;
          end
          if (rx_pos_q == LAST_POS) begin
            rxm_d = {1'b1, rx_frame_q, mbuf_q, desc};
            if (rx_frame_q >= 3'h2) begin
              rcv_d = {rcv_q[7:0], desc}; // R13
            end
          end
          if (r_end) begin
            if (chk_q) begin
              err_d = (full != rx_prev_q);
              febe_d = (full == rx_prev_q); // R15
            end
            rx_prev_d = rx_crc;
            chk_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ufr_pkg::UFR_HUNT;
      hist_q <= '0;
      rx_pos_q <= 7'h0;
      rx_frame_q <= 3'h0;
      mbuf_q <= '0;
      rcv_q <= '0;
      rx_prev_q <= '0;
      chk_q <= 1'b0;
      err_q <= 1'b0;
      febe_q <= 1'b1;
      lag_q <= 1'b0;
      rx_user_valid <= 1'b0;
      rx_user_bits <= '0;
      rx_m <= '0;
    end else if (ce) begin
      st_q <= st_d;
      hist_q <= hist_d;
      rx_pos_q <= rx_pos_d;
      rx_frame_q <= rx_frame_d;
      mbuf_q <= mbuf_d;
      rcv_q <= rcv_d;
      rx_prev_q <= rx_prev_d;
      chk_q <= chk_d;
      err_q <= err_d;
      febe_q <= febe_d;
      lag_q <= lag_d;
      rx_user_valid <= uv_d;
      rx_user_bits <= ub_d;
      rx_m <= rxm_d;
    end
  end

  ufr_scrambler #(.ORDER(`UFR_SCR_ORDER), .TAP(TAP_RX), .DESCR(1'b1)) u_dscr (
    .clk(clk), .rst(rst), .ce(ce), // R8
    .step(step && st_q == ufr_pkg::UFR_LOCK && rx_pos_q >= 7'(`UFR_SYNC_QUATS)),
    .din(rx_quat), .dout(desc)
  );

  ufr_crc #(.W(`UFR_CRC_W), .POLY(`UFR_CRC_POLY)) u_rx_crc (
    .clk(clk), .rst(rst), .ce(ce), .clr(r_end), .en_s(r_data), // R14
    .en_m(r_data || (step && st_q == ufr_pkg::UFR_LOCK && rx_pos_q == 7'(`UFR_M34_POS))),
    .d(desc), .crc(rx_crc)
  );

  assign tx_sym = sym_q;
  assign tx_user_take = take_q;
  assign rx_locked = (st_q == ufr_pkg::UFR_LOCK);
  assign rx_crc_err = err_q;
  assign rx_lag_ok = lag_q;

  // ==========================================
  // Checks
  logic [15:0] gap_q;
  logic seen_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (ce) begin
      gap_q <= sym_q.valid ? 16'h0 : gap_q + 16'h1;
      seen_q <= seen_q | sym_q.valid;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence sf_last_s;
    tick && tx_pos_q == LAST_POS && tx_frame_q == 3'h7;
  endsequence
  sequence isw_first_s;
    sym_q.valid && emit_pos_q == 7'h0 && emit_frame_q == 3'h0;
  endsequence

  quat_map_a: assert property (sym_q.valid |-> sym_q.level[0] && // R2
    sym_q.level[2] == !sym_q.q.sign && sym_q.level[1] == (sym_q.q.sign ^ sym_q.q.mag))
    else $error("quat level does not match bit pair");
  quat_gap_a: assert property (sym_q.valid && seen_q |-> gap_q == 16'(QUAT_CYC - 1)) // R3
    else $error("quat spacing wrong");
  frame_wrap_a: assert property (tick && tx_pos_q == LAST_POS |=> tx_pos_q == 7'h0) // R3
    else $error("frame length wrong");
  sync_a: assert property (sym_q.valid && emit_pos_q < 7'(`UFR_SYNC_QUATS) |-> // R4
    sym_q.sync && sym_q.q == sync_quat(emit_pos_q, emit_frame_q == 3'h0))
    else $error("syncword quat wrong");
  sf_wrap_a: assert property (sf_last_s |=> tx_frame_q == 3'h0 ##1 !sym_q.valid) // R5
    else $error("superframe not eight frames");
  isw_a: assert property (isw_first_s |-> sym_q.q.sign != SYNC_WORD[17]) // R6
    else $error("first frame lacks inverted sync");
  user_take_a: assert property (take_q |-> sym_q.valid && // R9
    emit_pos_q >= 7'(`UFR_SYNC_QUATS) && emit_pos_q <= 7'(`UFR_DATA_LAST))
    else $error("user bits taken outside data field");
  m4_one_a: assert property (sym_q.valid && emit_pos_q == 7'(`UFR_M34_POS) && // R11
    emit_frame_q inside {3'h2, 3'h3, 3'h4, 3'h5} |-> plain_q.mag)
    else $error("reserved M4 not one");
  m56_first_a: assert property (sym_q.valid && emit_pos_q == LAST_POS && // R12
    emit_frame_q == 3'h0 |-> plain_q == 2'h3)
    else $error("M5 M6 not one in frame one");
  febe_err_a: assert property (r_end && chk_q |=> febe_q == !err_q) // R15
    else $error("febe does not follow crc result");
endmodule // ufr_framer
`default_nettype wire

// File: test/ufr_far_end.sv
/*
  Far-end transceiver model: framed, scrambled quat stream into the framer.
  Assumes it shares the framer clock and sends one quat per framer tx quat.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ufr_params.svh"
module ufr_far_end (
  input wire logic clk, // System clock
  input wire logic rst, // Sync reset
  input wire ufr_pkg::ufr_tx_sym_t tx_sym, // Pacing quats
  input wire logic [9:0] lag, // Stream start in quats
  input wire logic crc_bad, // Corrupt sent CRC
  output logic rx_quat_valid, // Quat strobe
  output ufr_pkg::ufr_quat_t rx_quat // Quat sent
);
  int t, s, k;
  logic [2:0] f;
  logic [6:0] p;
  logic [22:0] h;
  logic [11:0] c, cs;
  logic [5:0] mb;
  logic [1:0] b;
  logic on;

  initial begin
    rx_quat_valid = 1'b0;
    rx_quat = '0;
  end

  // ==========================================
  // Stream builder
  always @(posedge clk) begin
    rx_quat_valid <= 1'b0;
    rx_quat <= ~rx_quat; // Idle line keeps moving
    if (rst) begin
      {t, s, k, h, c, cs, on} = '0;
    end else if (tx_sym.valid) begin
      on = on || t == int'(lag);
      t++;
      if (on) begin
        f = 3'(s / 120);
        p = 7'(s % 120);
        mb = {f, 1'b1, f < 3'd2 ? 2'b11 : cs[15 - 2 * f -: 2] ^ {2{crc_bad}}};
        if (p < 7'd9) begin
          b = 2'(`UFR_SYNC_WORD >> (16 - 2 * p)) ^ {f == 3'd0, 1'b0};
        end else begin
          b = p < 7'd117 ? 2'(k ^ (k >> 3)) : mb[239 - 2 * p -: 2];
          k = p < 7'd117 ? k + 1 : k;
          for (int i = 1; i >= 0; i--) begin
            if (p < 7'd117 || (p == 7'd118 && i == 0))
              c = {c[10:0], 1'b0} ^ (c[11] ^ b[i] ? `UFR_CRC_POLY : 12'h000);
            b[i] = b[i] ^ h[`UFR_SCR_TAP_RX - 1] ^ h[22];
            h = {h[21:0], b[i]};
          end
        end
        if (s == 959) begin
          cs = c;
          c = '0;
        end
        s = s == 959 ? 0 : s + 1;
        rx_quat_valid <= 1'b1;
        rx_quat <= b;
      end
    end
  end
endmodule // ufr_far_end
`default_nettype wire

// File: test/tb_top.sv
/*
  Testbench of the U-interface framer: coding, framing, scrambling,
  overhead and CRC on transmit; lock, descrambling, CRC check and
  offset status on receive.
  Assumes the far-end model ufr_far_end on the line side.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ufr_params.svh"
module tb_top;
  localparam int QC = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [9:0] lag = 10'd60;
  logic crc_bad = 1'b0;
  ufr_pkg::ufr_quat_t tx_user_bits = '0;
  ufr_pkg::ufr_ovh_t tx_ovh = 16'hb815;
  logic tx_user_take, rx_quat_valid, rx_user_valid, rx_locked, rx_crc_err, rx_lag_ok;
  ufr_pkg::ufr_tx_sym_t tx_sym;
  ufr_pkg::ufr_quat_t rx_quat, rx_user_bits;
  ufr_pkg::ufr_rx_m_t rx_m;
  int fail_count = 0;
  int check_count = 0;
  int pos, frm, gap, tk, sfc, rk, bad_tx, bad_rx, febe0, err_seen;
  logic [2:0] rf, lv;
  logic [1:0] d, sw;
  logic [22:0] dh;
  logic [11:0] crc, crc_prev, crc_old;
  logic [5:0] m_seen [8];
  logic [3:0] m_exp [8] = '{4'ha, 4'hd, 4'h1, 4'h3, 4'hb, 4'hd, 4'h0, 4'h3};

  ufr_framer #(.QUAT_CYC(QC)) dut (.clk(clk), .rst(rst), .ce(ce),
    .tx_user_bits(tx_user_bits), .tx_ovh(tx_ovh), .tx_user_take(tx_user_take),
    .tx_sym(tx_sym), .rx_quat_valid(rx_quat_valid), .rx_quat(rx_quat),
    .rx_user_valid(rx_user_valid), .rx_user_bits(rx_user_bits), .rx_m(rx_m),
    .rx_locked(rx_locked), .rx_crc_err(rx_crc_err), .rx_lag_ok(rx_lag_ok));
  ufr_far_end far (.clk(clk), .rst(rst), .tx_sym(tx_sym), .lag(lag), .crc_bad(crc_bad),
    .rx_quat_valid(rx_quat_valid), .rx_quat(rx_quat));

  always #5 clk = ~clk;

  function automatic logic [1:0] pat(int n);
    return 2'(n ^ (n >> 3));
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // Line and user-side monitor, user data source
  always @(negedge clk) begin
    gap++;
    if (rst) begin
      {pos, frm, gap, tk, sfc, rk, bad_tx, bad_rx} = '0;
      {rf, dh, crc, crc_prev, crc_old, tx_user_bits} = '0;
    end else begin
      if (tx_sym.valid) begin
        sw = 2'(`UFR_SYNC_WORD >> (16 - 2 * pos)) ^ {frm == 0, 1'b0};
        lv = tx_sym.q.sign ? (tx_sym.q.mag ? 3'h1 : 3'h3) : (tx_sym.q.mag ? 3'h7 : 3'h5);
        if (tx_sym.level !== lv || tx_sym.sync !== (pos < 9) || (pos < 9 && tx_sym.q !== sw)
            || tx_user_take !== (pos > 8 && pos < 117) || (sfc + frm + pos > 0 && gap != QC))
          bad_tx++;
        gap = 0;
        if (pos > 8) begin
          for (int i = 1; i >= 0; i--) begin
            d[i] = tx_sym.q[i] ^ dh[`UFR_SCR_TAP_TX - 1] ^ dh[22];
            dh = {dh[21:0], tx_sym.q[i]};
            if (pos < 117 || (pos == 118 && i == 0))
              crc = {crc[10:0], 1'b0} ^ (crc[11] ^ d[i] ? `UFR_CRC_POLY : 12'h000);
          end
          if (pos < 117 && d !== pat(tk)) bad_tx++;
          if (pos > 116) m_seen[frm][239 - 2 * pos -: 2] = d;
          else tk++;
          tx_user_bits = pat(tk);
          if (pos == 119 && frm == 1 && d[0] === 1'b0) febe0++;
        end
        pos = pos == 119 ? 0 : pos + 1;
        if (pos == 0) begin
          frm = frm == 7 ? 0 : frm + 1;
          if (frm == 0) begin
            {crc_old, crc_prev, crc} = {crc_prev, crc, 12'h000};
            sfc++;
          end
        end
      end
      if (rx_user_valid) begin
        if (rk >= 108 && rx_user_bits !== pat(rk)) bad_rx++;
        rk++;
      end
      if (rx_m.valid) begin
        if (rx_m.frame !== rf || rx_m.m[5:2] !== {rf, 1'b1}) bad_rx++;
        rf++;
      end
      if (rx_crc_err === 1'b1) err_seen++;
    end
  end

  task automatic wait_sf(int n);
    int t0;
    t0 = sfc;
    for (int i = 0; i < 5000 * n && sfc < t0 + n; i++) @(negedge clk);
  endtask

  task automatic do_reset(logic [9:0] l);
    @(negedge clk);
    rst = 1'b1;
    lag = l;
    repeat (5) @(negedge clk);
    check("reset outputs", {tx_sym, tx_user_take, rx_user_valid, rx_user_bits, rx_m,
      rx_locked, rx_crc_err, rx_lag_ok}, 0);
    rst = 1'b0;
  endtask

  // ==========================================
  // Scenarios
  task automatic test_tx_frames();
    wait_sf(2);
    check("tx coding", bad_tx, 0);
    for (int i = 0; i < 8; i++)
      check("tx m1 to m4", m_seen[i][5:2], m_exp[i]);
    check("tx early m5 m6", {m_seen[0][1:0], m_seen[1][1:0]}, 4'hf);
    check("tx crc", {m_seen[2][1:0], m_seen[3][1:0], m_seen[4][1:0], m_seen[5][1:0],
      m_seen[6][1:0], m_seen[7][1:0]}, crc_old);
  endtask

  task automatic test_rx_path();
    wait_sf(2);
    check("rx lock", rx_locked, 1);
    check("rx data", bad_rx, 0);
    check("rx amount", rk > 1000, 1);
    check("rx crc", rx_crc_err, 0);
    check("rx offset", rx_lag_ok, 1);
  endtask

  task automatic test_crc_error();
    {febe0, err_seen} = '0;
    crc_bad = 1'b1;
    wait_sf(1);
    crc_bad = 1'b0;
    wait_sf(2);
    check("crc error seen", err_seen > 0, 1);
    check("febe sent", febe0 > 0, 1);
    wait_sf(2);
    check("crc error clear", rx_crc_err, 0);
    check("febe clear", m_seen[1][0], 1);
    check("tx coding after", bad_tx, 0);
  endtask

  task automatic test_lag(logic [9:0] l, logic ok);
    do_reset(l);
    wait_sf(2);
    check("lag lock", rx_locked, 1);
    check("lag status", rx_lag_ok, ok);
  endtask

  initial begin
    do_reset(10'd60);
    test_tx_frames();
    test_rx_path();
    test_crc_error();
    test_lag(10'd62, 1'b1);
    test_lag(10'd63, 1'b0);
    test_lag(10'd58, 1'b1);
    test_lag(10'd57, 1'b0);
    give_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
